// file: inc/ors_pkg.sv
// Package with constants and types of the output ramp sequencer
// Overview of operation
// (R1) Eight load-regulation slopes, zero to largest, selectable and applied.
// (R2) Non-zero slope lowers output target in proportion to measured current.
// (R3) After turn-on command wait the on delay, then start ramping upward.
// (R4) With fall rate set, off delay spans command until output reaches zero.
// (R5) Without fall rate, both switches go off when off delay expires.
// (R6) Rate-controlled off waits off delay minus ramp-down time before ramping down.
// (R7) Manager programs off delay longer than the ramp-down time.
// (R8) Off-delay field is bits 5:0, delay in whole milliseconds, 0 to 63.
// (R9) Off-delay field resets to 11 milliseconds.
// (R10) Off-delay register bits 7:6 always read zero.
// (R11) Setpoint ramps in fixed 10 mV steps timed to meet the slew rate.
// (R12) Step time comes from dividing the manager's common master clock.
// (R13) Manager writes rise and fall rate selections into the ramp config register.
// (R14) Manager writes on and off delays into their delay registers.
// (R15) Into pre-bias, stage stays off until rising setpoint passes output level; an off command before that turns it on in the off delay.
// (R16) Manager rewrites all setup registers at power-up; copies reset to defaults.
// (R17) Delays count whole milliseconds from master clock; new off command restarts.
// (R18) Stepper stops exactly at target, clamping the last step.
package ors_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_RAMP_CFG = 8'h03;
    localparam logic [7:0] ADDR_ON_DLY   = 8'h05;
    localparam logic [7:0] ADDR_OFF_DLY  = 8'h06;
    localparam logic [7:0] ADDR_LOADREG  = 8'h08;
    localparam logic [7:0] ADDR_RUN      = 8'h15;

    // Reset values
    localparam logic [7:0] RST_RAMP_CFG = 8'h00;
    localparam logic [7:0] RST_ON_DLY   = 8'h00;
    localparam logic [5:0] RST_OFF_DLY  = 6'h0B;
    localparam logic [2:0] RST_LOADREG  = 3'h0;

    // Field positions
    localparam int RISE_LSB = 0;
    localparam int FALL_LSB = 4;

    // Setpoint: 12 bit, 2.5 mV per LSB; a 10 mV step is 4 LSB
    localparam int          VW       = 12;
    localparam logic [11:0] STEP_LSB = 12'h004;

    // Master clock edges per millisecond (500 kHz master clock)
    localparam logic [9:0] MCLK_PER_MS = 10'h1F4;

    // Droop coefficient: LSB per amp times 256; current input is 1/16 A per LSB
    localparam int DROOP_SHIFT = 12;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ONDLY = 3'b001,
        ST_RISE  = 3'b010,
        ST_REG   = 3'b011,
        ST_OFFDL = 3'b100,
        ST_FALL  = 3'b101
    } ors_state_t;

    // Master clock edges per 10 mV step for a slew-rate code
    function automatic logic [5:0] ors_step_edges(input logic [3:0] code);
        logic [5:0] e;
        e = 6'h01;
        case (code[2:0])
            3'd1:    e = 6'h32;  // 0.1 V/ms
            3'd2:    e = 6'h19;  // 0.2 V/ms
            3'd3:    e = 6'h0A;  // 0.5 V/ms
            3'd4:    e = 6'h05;  // 1 V/ms
            3'd5:    e = 6'h03;  // about 1.7 V/ms
            3'd6:    e = 6'h02;  // 2.5 V/ms
            default: e = 6'h01;  // 5 V/ms
        endcase
        return e;
    endfunction : ors_step_edges

    // Load-regulation coefficient, LSB per amp times 256
    function automatic logic [9:0] ors_droop_coef(input logic [2:0] code);
        logic [9:0] c;
        c = 10'h000;
        case (code)
            3'd1:    c = 10'h04C;  // 0.74 mV/A
            3'd2:    c = 10'h099;  // 1.49 mV/A
            3'd3:    c = 10'h0E4;  // 2.23 mV/A
            3'd4:    c = 10'h11E;  // 2.79 mV/A
            3'd5:    c = 10'h17C;  // 3.71 mV/A
            3'd6:    c = 10'h1C9;  // 4.46 mV/A
            3'd7:    c = 10'h214;  // 5.2 mV/A
            default: c = 10'h000;  // 0 mV/A
        endcase
        return c;
    endfunction : ors_droop_coef

endpackage : ors_pkg

// file: verilog/ors_tick_div.sv
// Master clock synchroniser and divider giving edge and millisecond ticks
`timescale 1ns/1ps
module ors_tick_div (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Master clock pin
    input  wire logic i_master_clk,
    // Ticks
    output logic      o_edge_tick,
    output logic      o_ms_tick
);
    import ors_pkg::*;

    logic       sync1_ff;
    logic       sync2_ff;
    logic       prev_ff;
    logic [9:0] ms_cnt_ff;

    // Two flops before any logic looks at the pin
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= i_master_clk;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_edge_tick <= 1'b0;
        end else begin
            o_edge_tick <= sync2_ff & ~prev_ff; // (R12)
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ms_cnt_ff <= 10'h000;
            o_ms_tick <= 1'b0;
        end else begin
            o_ms_tick <= 1'b0;
            if (sync2_ff & ~prev_ff) begin
                if (ms_cnt_ff == MCLK_PER_MS - 10'h001) begin
                    ms_cnt_ff <= 10'h000;
                    o_ms_tick <= 1'b1; // (R17)
                end else begin
                    ms_cnt_ff <= ms_cnt_ff + 10'h001;
                end
            end
        end
    end

endmodule : ors_tick_div

// file: verilog/ors_sequencer.sv
// Turn-on/off sequencer, setpoint ramp stepper and load-line regulation
`timescale 1ns/1ps
module ors_sequencer (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Master clock pin from the power manager
    input  wire logic        i_master_clk,
    // Register port
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // Commands
    input  wire logic        i_on_cmd,
    input  wire logic        i_off_cmd,
    // Target and measurements
    input  wire logic [11:0] i_vset,
    input  wire logic [11:0] i_vout_meas,
    input  wire logic [7:0]  i_iout_meas,
    // Power stage control
    output logic [11:0]      o_setpoint,
    output logic [11:0]      o_reg_target,
    output logic             o_stage_en,
    output ors_pkg::ors_state_t o_state
);
    import ors_pkg::*;

    logic [7:0]  ramp_cfg_ff;
    logic [7:0]  on_dly_ff;
    logic [5:0]  off_dly_ff;
    logic [2:0]  loadreg_ff;
    logic        edge_tick;
    logic        ms_tick;
    ors_state_t  state_ff;
    logic [7:0]  ms_cnt_ff;
    logic [17:0] off_elapsed_ff;
    logic [17:0] fall_ticks_ff;
    logic [5:0]  step_cnt_ff;
    logic        prebias_ok_ff;
    logic [5:0]  rise_edges;
    logic [5:0]  fall_edges;
    logic        fall_set;
    logic [17:0] off_total;
    logic [17:0] nxt_fall_ticks;
    logic        step_due;
    logic [17:0] droop_prod;
    logic [11:0] droop;

    assign rise_edges = ors_step_edges(ramp_cfg_ff[RISE_LSB +: 4]);
    assign fall_edges = ors_step_edges(ramp_cfg_ff[FALL_LSB +: 4]);
    assign fall_set   = ramp_cfg_ff[FALL_LSB +: 4] != 4'h0;

    // Whole milliseconds converted into master clock edges
    assign off_total = 18'(off_dly_ff) * 18'(MCLK_PER_MS); // (R8)
    // Ramp-down length in master clock edges; a part step costs a whole step,
    // so zero lands at the end of the delay rather than one step late
    assign nxt_fall_ticks = 18'(({1'b0, o_setpoint} + 13'h0003) >> 2) * 18'(fall_edges); // (R6)

    ors_tick_div u_div (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_master_clk (i_master_clk),
        .o_edge_tick  (edge_tick),
        .o_ms_tick    (ms_tick)
    );

    // Register writes; all copies fall back to defaults on reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ramp_cfg_ff <= RST_RAMP_CFG;
            on_dly_ff   <= RST_ON_DLY;
            off_dly_ff  <= RST_OFF_DLY; // (R9)
            loadreg_ff  <= RST_LOADREG;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_RAMP_CFG: ramp_cfg_ff <= i_reg_wdata; // (R13)
                ADDR_ON_DLY:   on_dly_ff   <= i_reg_wdata; // (R14)
                ADDR_OFF_DLY:  off_dly_ff  <= i_reg_wdata[5:0]; // (R8)
                ADDR_LOADREG:  loadreg_ff  <= i_reg_wdata[2:0]; // (R1)
                default:       ramp_cfg_ff <= ramp_cfg_ff;
            endcase
        end
    end

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                ADDR_RAMP_CFG: o_reg_rdata <= ramp_cfg_ff;
                ADDR_ON_DLY:   o_reg_rdata <= on_dly_ff;
                ADDR_OFF_DLY:  o_reg_rdata <= {2'b00, off_dly_ff}; // (R10)
                ADDR_LOADREG:  o_reg_rdata <= {5'h00, loadreg_ff};
                ADDR_RUN:      o_reg_rdata <= {4'h0, o_stage_en, o_state};
                default:       o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Step pacing: one 10 mV step every N master clock edges
    assign step_due = edge_tick &&
        (step_cnt_ff + 6'h01 >= ((state_ff == ST_FALL) ? fall_edges : rise_edges)); // (R11)

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            step_cnt_ff <= 6'h00;
        end else if (state_ff != ST_RISE && state_ff != ST_FALL) begin
            step_cnt_ff <= 6'h00;
        end else if (step_due) begin
            step_cnt_ff <= 6'h00;
        end else if (edge_tick) begin
            step_cnt_ff <= step_cnt_ff + 6'h01; // (R12)
        end
    end

    // Sequencing state machine
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff       <= ST_IDLE;
            ms_cnt_ff      <= 8'h00;
            off_elapsed_ff <= 18'h0_0000;
            fall_ticks_ff  <= 18'h0_0000;
            o_setpoint     <= 12'h000;
            prebias_ok_ff  <= 1'b0;
        end else if (i_off_cmd && state_ff != ST_IDLE) begin
            // A fresh off command in any state but idle starts the off sequence over
            state_ff       <= ST_OFFDL; // (R17)
            off_elapsed_ff <= 18'h0_0000;
            fall_ticks_ff  <= nxt_fall_ticks; // (R6)
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (i_on_cmd) begin
                        state_ff      <= ST_ONDLY;
                        ms_cnt_ff     <= 8'h00;
                        o_setpoint    <= 12'h000;
                        prebias_ok_ff <= 1'b0;
                    end
                end
                ST_ONDLY: begin
                    if (ms_cnt_ff >= on_dly_ff) begin
                        state_ff <= ST_RISE; // (R3)
                    end else if (ms_tick) begin
                        ms_cnt_ff <= ms_cnt_ff + 8'h01; // (R17)
                    end
                end
                ST_RISE: begin
                    if (o_setpoint >= i_vout_meas) begin
                        prebias_ok_ff <= 1'b1; // (R15)
                    end
                    if (o_setpoint >= i_vset) begin
                        o_setpoint <= i_vset;
                        state_ff   <= ST_REG;
                    end else if (step_due) begin
                        // Last step is clamped so the target is never passed
                        o_setpoint <= (i_vset - o_setpoint <= STEP_LSB) ?
                                      i_vset : o_setpoint + STEP_LSB; // (R18)
                    end
                end
                ST_REG: begin
                    o_setpoint <= i_vset;
                end
                ST_OFFDL: begin
                    if (edge_tick) begin
                        off_elapsed_ff <= off_elapsed_ff + 18'h0_0001;
                    end
                    if (fall_set) begin
                        // Ramp starts so that zero lands at the end of the delay;
                        // if the delay is too short the ramp starts at once
                        if (off_elapsed_ff + fall_ticks_ff >= off_total) begin
                            state_ff <= ST_FALL; // (R4)
                        end
                    end else if (off_elapsed_ff >= off_total) begin
                        state_ff      <= ST_IDLE; // (R5)
                        o_setpoint    <= 12'h000;
                        prebias_ok_ff <= 1'b0;
                    end
                end
                ST_FALL: begin
                    if (o_setpoint == 12'h000) begin
                        state_ff      <= ST_IDLE; // (R4)
                        prebias_ok_ff <= 1'b0;
                    end else if (step_due) begin
                        o_setpoint <= (o_setpoint <= STEP_LSB) ?
                                      12'h000 : o_setpoint - STEP_LSB; // (R18)
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_state <= ST_IDLE;
        end else begin
            o_state <= state_ff;
        end
    end

    // Power stage held off into pre-bias until the ramp crosses the output or an off command enters the off delay
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stage_en <= 1'b0;
        end else begin
            case (state_ff)
                ST_RISE:  o_stage_en <= prebias_ok_ff || (o_setpoint >= i_vout_meas); // (R15)
                ST_REG:   o_stage_en <= 1'b1;
                ST_OFFDL: o_stage_en <= 1'b1;
                ST_FALL:  o_stage_en <= 1'b1;
                default:  o_stage_en <= 1'b0; // (R5)
            endcase
        end
    end

    // Load line: target drops with measured current
    assign droop_prod = 18'(i_iout_meas) * 18'(ors_droop_coef(loadreg_ff)); // (R1)
    assign droop      = 12'(droop_prod >> DROOP_SHIFT);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_target <= 12'h000;
        end else begin
            o_reg_target <= (o_setpoint > droop) ? o_setpoint - droop : 12'h000; // (R2)
        end
    end

endmodule : ors_sequencer

// file: tb/ors_seq_sva.sv
// Port checker for the output ramp sequencer
`timescale 1ns/1ps
module ors_seq_sva
    import ors_pkg::*;
(
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    // Register port and commands
    input wire logic        i_master_clk,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_on_cmd,
    input wire logic        i_off_cmd,
    // Measurements and outputs
    input wire logic [11:0] i_vset,
    input wire logic [11:0] i_vout_meas,
    input wire logic [7:0]  i_iout_meas,
    input wire logic [11:0] o_setpoint,
    input wire logic [11:0] o_reg_target,
    input wire logic        o_stage_en,
    input wire ors_state_t  o_state
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_off_hi_zero: assert property (
        $past(i_reg_addr) == ADDR_OFF_DLY |-> o_reg_rdata[7:6] == 2'b00)
        else $error("Off delay high bits not zero");
    a_off_wr_rb: assert property (
        i_reg_wr && i_reg_addr == ADDR_OFF_DLY ##1 i_reg_addr == ADDR_OFF_DLY
        |=> o_reg_rdata == {2'b00, $past(i_reg_wdata[5:0], 2)})
        else $error("Off delay readback wrong");
    // The state output trails the internal state by one cycle, so the state
    // that meets a command is the one shown on the cycle after it
    a_on_to_dly: assert property (
        i_on_cmd && !i_off_cmd ##1 o_state == ST_IDLE |-> ##1 o_state == ST_ONDLY)
        else $error("Turn-on did not start the delay");
    a_dly_quiet: assert property (
        o_state == ST_ONDLY |-> o_setpoint == 12'h000 && !o_stage_en)
        else $error("Output moved during turn-on delay");
    a_rise_step: assert property (
        o_state == ST_RISE && $changed(o_setpoint)
        |-> o_setpoint - $past(o_setpoint) <= STEP_LSB && o_setpoint <= i_vset)
        else $error("Rising step too large or past target");
    a_fall_step: assert property (
        o_state == ST_FALL && $changed(o_setpoint)
        |-> $past(o_setpoint) - o_setpoint <= STEP_LSB)
        else $error("Falling step too large");
    a_prebias_hold: assert property (
        $rose(o_stage_en) |-> o_setpoint >= i_vout_meas)
        else $error("Stage enabled below pre-bias level");
    a_fall0_zero: assert property (
        o_state == ST_OFFDL ##1 o_state == ST_IDLE |-> o_setpoint == 12'h000 && !o_stage_en)
        else $error("Switches still on after off delay");
    a_off_restart: assert property (
        i_off_cmd ##1 o_state != ST_IDLE |-> ##1 o_state == ST_OFFDL)
        else $error("Turn-off did not restart the off delay");

    c_regulate: cover property (o_state == ST_REG);
    c_falling: cover property (o_state == ST_FALL);
    c_prebias: cover property ($rose(o_stage_en) && i_vout_meas != 12'h000);
endmodule : ors_seq_sva

bind ors_sequencer ors_seq_sva u_sva (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_master_clk(i_master_clk),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_on_cmd(i_on_cmd), .i_off_cmd(i_off_cmd),
    .i_vset(i_vset), .i_vout_meas(i_vout_meas), .i_iout_meas(i_iout_meas),
    .o_setpoint(o_setpoint), .o_reg_target(o_reg_target), .o_stage_en(o_stage_en),
    .o_state(o_state)
);

// file: tb/ors_pm_model.sv
// Power manager model: master clock, register writes, reads and commands
`timescale 1ns/1ps
module ors_pm_model (
    // Clock and read data
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    // Master clock, register port and commands
    output logic            o_master_clk,
    output logic            o_reg_wr,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_on_cmd,
    output logic            o_off_cmd
);
    // Free-running common clock; period scaled to 20 ns so millisecond counts fit the run
    initial o_master_clk = 1'b0;
    always #10 o_master_clk = ~o_master_clk;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_on_cmd = 1'b0;
        o_off_cmd = 1'b0;
    end
    // Setup block written after power-up: delays and ramp rates
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(posedge i_sys_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_addr = a;
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        #1;
        d = i_reg_rdata;
    endtask : read_reg
    task automatic pulse(input logic off);
        @(posedge i_sys_clk);
        #1;
        o_on_cmd = !off;
        o_off_cmd = off;
        @(posedge i_sys_clk);
        #1;
        o_on_cmd = 1'b0;
        o_off_cmd = 1'b0;
    endtask : pulse
endmodule : ors_pm_model

// file: tb/tb.sv
// Self-checking bench for the output ramp sequencer
`timescale 1ns/1ps
module tb;
    import ors_pkg::*;
    // System cycles per millisecond with the 20 ns master clock
    localparam int MS  = 2000;
    localparam int TOL = 80;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [11:0] i_vset = 12'h102;
    logic [11:0] i_vout_meas = 12'h000;
    logic [7:0]  i_iout_meas = 8'h00;
    wire         i_master_clk;
    wire         i_reg_wr;
    wire  [7:0]  i_reg_addr;
    wire  [7:0]  i_reg_wdata;
    wire         i_on_cmd;
    wire         i_off_cmd;
    wire  [7:0]  o_reg_rdata;
    wire  [11:0] o_setpoint;
    wire  [11:0] o_reg_target;
    wire         o_stage_en;
    ors_state_t  o_state;
    logic [7:0]  rd;
    int          n;
    int          m;
    int          num_errors = 0;
    int          num_checks = 0;
    // Rows: offset, write data, expected readback
    logic [23:0] rows [7] = '{24'h06_FF3F, 24'h06_0000, 24'h07_5A00, 24'h08_0707,
                              24'h05_0101, 24'h06_0202, 24'h03_0404};
    int          coef [8] = '{0, 76, 153, 228, 286, 380, 457, 532};

    always #2.5 i_sys_clk = ~i_sys_clk;

    ors_pm_model pm (.i_sys_clk(i_sys_clk), .i_reg_rdata(o_reg_rdata),
        .o_master_clk(i_master_clk), .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr),
        .o_reg_wdata(i_reg_wdata), .o_on_cmd(i_on_cmd), .o_off_cmd(i_off_cmd));
    ors_sequencer dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_master_clk(i_master_clk),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_on_cmd(i_on_cmd), .i_off_cmd(i_off_cmd),
        .i_vset(i_vset), .i_vout_meas(i_vout_meas), .i_iout_meas(i_iout_meas),
        .o_setpoint(o_setpoint), .o_reg_target(o_reg_target), .o_stage_en(o_stage_en),
        .o_state(o_state));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_state(input ors_state_t st, output int cnt);
        cnt = 0;
        while (o_state !== st && cnt < 20000) begin
            @(posedge i_sys_clk);
            #1;
            cnt++;
        end
        if (cnt >= 20000) num_errors++;
    endtask : wait_state

    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Run takes about 15k cycles; the margin covers slow ramps
    initial begin
        repeat (50000) @(posedge i_sys_clk);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        pm.read_reg(ADDR_OFF_DLY, rd);
        check(rd, RST_OFF_DLY);
        pm.read_reg(ADDR_RUN, rd);
        check(rd, 8'h00);
        // Last off delay row is longer than any ramp-down used here
        foreach (rows[k]) begin
            pm.write_reg(rows[k][23:16], rows[k][15:8]);
            pm.read_reg(rows[k][23:16], rd);
            check(rd, rows[k][7:0]);
        end
        pm.pulse(1'b0);
        wait_state(ST_RISE, n);
        check(n > MS - TOL && n < MS + TOL, 1'b1);
        wait_state(ST_REG, n);
        check({o_stage_en, o_setpoint}, {1'b1, i_vset});
        i_iout_meas = 8'hFF;
        for (int c = 0; c < 8; c++) begin
            pm.write_reg(ADDR_LOADREG, 8'(c));
            repeat (4) @(posedge i_sys_clk);
            #1;
            check(o_reg_target, i_vset - 12'((255 * coef[c]) >> 12));
        end
        pm.write_reg(ADDR_LOADREG, 8'h00);
        pm.pulse(1'b1);
        repeat (MS / 2) @(posedge i_sys_clk);
        #1;
        check(o_state, ST_OFFDL);
        pm.pulse(1'b1);
        wait_state(ST_IDLE, n);
        check(n > 2 * MS - TOL && n < 2 * MS + TOL, 1'b1);
        check({o_stage_en, o_setpoint}, 13'h0000);
        i_vout_meas = 12'h080;
        pm.pulse(1'b0);
        wait_state(ST_RISE, n);
        check(o_stage_en, 1'b0);
        n = 0;
        while (o_stage_en !== 1'b1 && n < 4 * MS) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        check(o_setpoint >= 12'h080 && o_setpoint <= 12'h088, 1'b1);
        wait_state(ST_REG, n);
        pm.write_reg(ADDR_RAMP_CFG, 8'h44);
        pm.pulse(1'b1);
        // 65 steps of 5 master edges, 4 system cycles each
        wait_state(ST_FALL, n);
        check(n > 2 * MS - 1300 - TOL && n < 2 * MS - 1300 + TOL, 1'b1);
        wait_state(ST_IDLE, m);
        check(n + m > 2 * MS - TOL && n + m < 2 * MS + TOL, 1'b1);
        check({o_stage_en, o_setpoint}, 13'h0000);
        // Reset in mid-run drops the sequence and restores the register defaults
        pm.pulse(1'b0);
        repeat (4) @(posedge i_sys_clk);
        #1;
        check(o_state, ST_ONDLY);
        i_rst = 1'b1;
        @(posedge i_sys_clk);
        #1;
        check({o_stage_en, o_state, o_setpoint}, 16'h0000);
        i_rst = 1'b0;
        pm.read_reg(ADDR_OFF_DLY, rd);
        check(rd, RST_OFF_DLY);
        end_sim();
    end
endmodule : tb
